//--- src/sdrci_pkg.sv
// shared constants, command codes and decode helpers for both link ends
// assumes a single pclk domain; no state lives here
package sdrci_pkg;

	localparam int BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ROW_W = 11;
	localparam int COL_W = 8;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = BANK_W + ROW_W + COL_W;
	localparam int WORDS = 1 << ADDR_W;
	localparam int BEAT_W = 9;
	localparam int AP_BIT = 10;

	// {row strobe, column strobe, write enable} with chip select low
	localparam logic [2:0] OP_NOP = 3'h7;
	localparam logic [2:0] OP_ROW_OPEN = 3'h3;
	localparam logic [2:0] OP_READ = 3'h5;
	localparam logic [2:0] OP_WRITE = 3'h4;
	localparam logic [2:0] OP_BST = 3'h6;
	localparam logic [2:0] OP_PRE = 3'h2;
	localparam logic [2:0] OP_REF = 3'h1;
	localparam logic [2:0] OP_MRS = 3'h0;

	// mode setting layout
	localparam int MR_BL_LSB = 0;
	localparam int MR_BL_W = 3;
	localparam int MR_BT_BIT = 3;
	localparam int MR_LAT_LSB = 4;
	localparam int MR_LAT_W = 3;
	localparam int MR_WB_BIT = 9;
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] LAT_3 = 3'h3;
	localparam logic [10:0] MR_RESET = 11'h020;
	localparam logic [8:0] BEAT_ONE = 9'h001;

	// controller register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_CMD = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam int CTRL_CKE_BIT = 0;
	localparam int CTRL_LAT3_BIT = 1;
	localparam int ADDR_BANK_LSB = 12;
	localparam int ADDR_MASK_LSB = 16;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_RDV_BIT = 1;
	localparam logic [2:0] LAT_WAIT_2 = 3'h3;
	localparam logic [2:0] LAT_WAIT_3 = 3'h4;

	typedef enum logic [3:0] {
		DESEL_CMD, NOP_CMD, ROW_OPEN_CMD, READ_CMD, WRITE_CMD,
		PRE_CMD, REF_CMD, MRS_CMD, BST_CMD
	} sdrci_cmd_e;

	function automatic sdrci_cmd_e cmd_decode(input logic cs_n, input logic [2:0] op);
		sdrci_cmd_e c;
		c = NOP_CMD;
		if (cs_n)
			c = DESEL_CMD;
		else
		begin
			case (op)
				OP_NOP: c = NOP_CMD;
				OP_ROW_OPEN: c = ROW_OPEN_CMD;
				OP_READ: c = READ_CMD;
				OP_WRITE: c = WRITE_CMD;
				OP_BST: c = BST_CMD;
				OP_PRE: c = PRE_CMD;
				OP_REF: c = REF_CMD;
				OP_MRS: c = MRS_CMD;
			endcase
		end
		return c;
	endfunction : cmd_decode

	// unknown length codes fall back to one word
	function automatic logic [8:0] burst_words(input logic [2:0] code);
		logic [8:0] w;
		case (code)
			BL_2: w = 9'h002;
			BL_4: w = 9'h004;
			BL_8: w = 9'h008;
			BL_PAGE: w = 9'h100;
			default: w = BEAT_ONE;
		endcase
		return w;
	endfunction : burst_words

endpackage : sdrci_pkg

//--- src/sdrci_if.sv
// link between memory controller and sdram end
// assumes both ends share pclk; the bench instantiates and joins them here
`timescale 1ns/100ps
interface sdrci_if
(
	input logic pclk,
	input logic presetn
);
	logic clk_en;
	logic chip_sel_n;
	logic row_strobe_n;
	logic col_strobe_n;
	logic wr_en_n;
	logic [sdrci_pkg::BANK_W-1:0] bank_sel;
	logic [sdrci_pkg::ROW_W-1:0] addr_bus;
	logic [sdrci_pkg::LANES-1:0] byte_mask;
	logic [sdrci_pkg::DATA_W-1:0] ctl_dq_o;
	logic ctl_dq_oe;
	logic [sdrci_pkg::DATA_W-1:0] dev_dq_o;
	logic dev_dq_oe;
	logic [sdrci_pkg::DATA_W-1:0] data_bus;

	// resolved data wire; an undriven bus reads as zero
	assign data_bus = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);

	modport dev (input pclk, presetn, clk_en, chip_sel_n, row_strobe_n, col_strobe_n,
		wr_en_n, bank_sel, addr_bus, byte_mask, data_bus, output dev_dq_o, dev_dq_oe);
	modport ctl (input pclk, presetn, data_bus, output clk_en, chip_sel_n, row_strobe_n,
		col_strobe_n, wr_en_n, bank_sel, addr_bus, byte_mask, ctl_dq_o, ctl_dq_oe);
endinterface : sdrci_if

//--- src/sdrci_burst.sv
// burst column generator: start column plus beat index in the chosen order
// assumes beat index stays below the programmed length
`timescale 1ns/100ps
module sdrci_burst
(
	input logic [sdrci_pkg::COL_W-1:0] start_col,
	input logic [sdrci_pkg::COL_W-1:0] beat,
	input logic [2:0] len_code,
	input logic interleave,
	output logic [sdrci_pkg::COL_W-1:0] col
);
	logic [sdrci_pkg::BEAT_W-1:0] words;
	logic [sdrci_pkg::COL_W-1:0] wrap;
	logic [sdrci_pkg::COL_W-1:0] seq;

	assign words = sdrci_pkg::burst_words(len_code);
	assign wrap = sdrci_pkg::COL_W'(words - sdrci_pkg::BEAT_ONE);
	assign seq = interleave ? (start_col ^ beat) : sdrci_pkg::COL_W'(start_col + beat);
	// wraps inside the aligned block of the burst length
	assign col = (start_col & ~wrap) | (seq & wrap);
endmodule : sdrci_burst

//--- src/sdrci_dev.sv
// sdram end: command decode, bank state, mode setting, bursts and the array
// assumes the controller drives the link synchronously to pclk
// How it works
// - every link input sampled on rising pclk
// - burst column advances each clock; registered outputs
// - clock enable low freezes state next cycle
// - power down only when all banks idle
// - in power down only wake level watched
// - chip select high masks command; part of code
// - bank select picks target bank
// - row open latches eleven bit row
// - column from low eight bits; bit ten auto precharge
// - precharge bit ten high closes all banks
// - mode set loads address and bank lines
// - burst lengths 1,2,4,8,page; burst stop
// - latency 2/3, order, single write option
// - auto precharge closes row after burst
// - read or write needs an open row
// - controller refreshes all rows in time; here software issues each refresh
// - four byte masks, one per lane
// - masked lanes keep old write data
// - row open or precharge by write enable
// - read or write by write enable
`timescale 1ns/100ps
module sdrci_dev
(
	sdrci_if.dev link,
	output logic [sdrci_pkg::BANKS-1:0] bank_open,
	output logic power_down,
	output logic self_refresh,
	output logic [sdrci_pkg::ROW_W-1:0] refresh_row
);
	typedef struct packed {
		logic cke_q;
		logic pwr_down;
		logic self_ref;
		logic [sdrci_pkg::ROW_W-1:0] mode;
		logic [sdrci_pkg::BANK_W-1:0] mode_ba;
		logic [sdrci_pkg::BANKS-1:0] open;
		logic [sdrci_pkg::BANKS-1:0][sdrci_pkg::ROW_W-1:0] row;
		logic bst_act;
		logic bst_wr;
		logic bst_ap;
		logic [sdrci_pkg::BANK_W-1:0] bst_bank;
		logic [sdrci_pkg::COL_W-1:0] bst_col;
		logic [sdrci_pkg::BEAT_W-1:0] bst_beat;
		logic [sdrci_pkg::BEAT_W-1:0] bst_len;
		logic [1:0] pv;
		logic [1:0][sdrci_pkg::DATA_W-1:0] pd;
		logic [sdrci_pkg::DATA_W-1:0] dq_o;
		logic dq_oe;
		logic [sdrci_pkg::ROW_W-1:0] ref_row;
	} sdrci_dev_s;

	sdrci_dev_s state_r;
	sdrci_dev_s state_nxt;
	sdrci_pkg::sdrci_cmd_e cmd;
	logic running;
	logic new_rw;
	logic do_beat;
	logic beat_wr;
	logic beat_ap;
	logic lat3;
	logic [sdrci_pkg::BEAT_W-1:0] beat_len;
	logic [sdrci_pkg::BEAT_W-1:0] beat_next;
	logic [sdrci_pkg::BANK_W-1:0] b_bank;
	logic [sdrci_pkg::COL_W-1:0] b_start;
	logic [sdrci_pkg::COL_W-1:0] b_beat;
	logic [sdrci_pkg::COL_W-1:0] b_col;
	logic [sdrci_pkg::ADDR_W-1:0] m_addr;
	logic m_we;
	logic [sdrci_pkg::DATA_W-1:0] m_rd;
	logic [sdrci_pkg::DATA_W-1:0] mem [0:sdrci_pkg::WORDS-1];

	assign cmd = sdrci_pkg::cmd_decode(link.chip_sel_n,
		{link.row_strobe_n, link.col_strobe_n, link.wr_en_n});
	// internal clock runs only when enable was high at the previous edge
	assign running = state_r.cke_q && !state_r.pwr_down && !state_r.self_ref;
	// accesses to a closed bank are dropped rather than hitting a stale row
	assign new_rw = running && ((cmd == sdrci_pkg::READ_CMD) || (cmd == sdrci_pkg::WRITE_CMD))
		&& state_r.open[link.bank_sel];
	assign do_beat = new_rw || (running && state_r.bst_act && (cmd != sdrci_pkg::BST_CMD));
	assign b_bank = new_rw ? link.bank_sel : state_r.bst_bank;
	assign b_start = new_rw ? link.addr_bus[sdrci_pkg::COL_W-1:0] : state_r.bst_col;
	assign b_beat = new_rw ? '0 : state_r.bst_beat[sdrci_pkg::COL_W-1:0];
	assign beat_wr = new_rw ? (cmd == sdrci_pkg::WRITE_CMD) : state_r.bst_wr;
	assign beat_ap = new_rw ? link.addr_bus[sdrci_pkg::AP_BIT] : state_r.bst_ap;
	assign beat_len = !new_rw ? state_r.bst_len :
		((beat_wr && state_r.mode[sdrci_pkg::MR_WB_BIT]) ? sdrci_pkg::BEAT_ONE :
		sdrci_pkg::burst_words(state_r.mode[sdrci_pkg::MR_BL_LSB +: sdrci_pkg::MR_BL_W]));
	assign beat_next = (new_rw ? '0 : state_r.bst_beat) + sdrci_pkg::BEAT_ONE;
	assign lat3 = state_r.mode[sdrci_pkg::MR_LAT_LSB +: sdrci_pkg::MR_LAT_W]
		== sdrci_pkg::LAT_3;
	assign m_addr = {b_bank, state_r.row[b_bank], b_col};
	assign m_rd = mem[m_addr];
	assign m_we = do_beat && beat_wr;

	sdrci_burst u_burst
	(
		.start_col(b_start),
		.beat(b_beat),
		.len_code(state_r.mode[sdrci_pkg::MR_BL_LSB +: sdrci_pkg::MR_BL_W]),
		.interleave(state_r.mode[sdrci_pkg::MR_BT_BIT]),
		.col(b_col)
	);

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.cke_q = link.clk_en;
		if (state_r.pwr_down || state_r.self_ref)
		begin
			// buffers off: nothing but the wake level is looked at
			if (link.clk_en)
			begin
				state_nxt.pwr_down = 1'b0;
				state_nxt.self_ref = 1'b0;
			end
		end
		else if (state_r.cke_q)
		begin
			state_nxt.pv = {state_r.pv[0], do_beat && !beat_wr};
			state_nxt.pd = {state_r.pd[0], m_rd};
			state_nxt.dq_oe = lat3 ? state_r.pv[1] : state_r.pv[0];
			state_nxt.dq_o = lat3 ? state_r.pd[1] : state_r.pd[0];
			if (do_beat)
			begin
				if (beat_next == beat_len)
				begin
					state_nxt.bst_act = 1'b0;
					if (beat_ap)
						state_nxt.open[b_bank] = 1'b0;
				end
				else
				begin
					state_nxt.bst_act = 1'b1;
					state_nxt.bst_bank = b_bank;
					state_nxt.bst_col = b_start;
					state_nxt.bst_beat = beat_next;
					state_nxt.bst_len = beat_len;
					state_nxt.bst_wr = beat_wr;
					state_nxt.bst_ap = beat_ap;
				end
			end
			unique case (cmd)
				sdrci_pkg::ROW_OPEN_CMD:
				begin
					state_nxt.open[link.bank_sel] = 1'b1;
					state_nxt.row[link.bank_sel] = link.addr_bus;
				end
				sdrci_pkg::PRE_CMD:
				begin
					if (link.addr_bus[sdrci_pkg::AP_BIT])
						state_nxt.open = '0;
					else
						state_nxt.open[link.bank_sel] = 1'b0;
					if (link.addr_bus[sdrci_pkg::AP_BIT] || (link.bank_sel == state_r.bst_bank))
						state_nxt.bst_act = 1'b0;
				end
				sdrci_pkg::BST_CMD:
					state_nxt.bst_act = 1'b0;
				sdrci_pkg::MRS_CMD:
				begin
					// ignored unless every bank is idle
					if ((state_r.open == '0) && !state_r.bst_act)
					begin
						state_nxt.mode = link.addr_bus;
						state_nxt.mode_ba = link.bank_sel;
					end
				end
				sdrci_pkg::REF_CMD:
				begin
					if ((state_r.open == '0) && !link.clk_en)
						state_nxt.self_ref = 1'b1;
					else
						state_nxt.ref_row = state_r.ref_row + sdrci_pkg::ROW_W'(1);
				end
				sdrci_pkg::DESEL_CMD, sdrci_pkg::NOP_CMD, sdrci_pkg::READ_CMD,
				sdrci_pkg::WRITE_CMD:
				begin
				end
			endcase
			if (!link.clk_en && (state_r.open == '0) && !state_r.bst_act
				&& (cmd != sdrci_pkg::REF_CMD) && (cmd != sdrci_pkg::ROW_OPEN_CMD))
				state_nxt.pwr_down = 1'b1;
		end
	end

	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
		begin
			state_r <= '0;
			state_r.mode <= sdrci_pkg::MR_RESET;
			state_r.cke_q <= 1'b1;
		end
		else
			state_r <= state_nxt;
	end

	// array carries no reset; contents are undefined until written
	always_ff @(posedge link.pclk)
	begin
		if (m_we)
		begin
			for (int i = 0; i < sdrci_pkg::LANES; i++)
			begin
				if (!link.byte_mask[i])
					mem[m_addr][i*sdrci_pkg::BYTE_W +: sdrci_pkg::BYTE_W] <=
						link.data_bus[i*sdrci_pkg::BYTE_W +: sdrci_pkg::BYTE_W];
			end
		end
	end

	assign link.dev_dq_o = state_r.dq_o;
	assign link.dev_dq_oe = state_r.dq_oe;
	assign bank_open = state_r.open;
	assign power_down = state_r.pwr_down;
	assign self_refresh = state_r.self_ref;
	assign refresh_row = state_r.ref_row;
endmodule : sdrci_dev

//--- src/sdrci_ctl.sv
// controller end: apb register slave that issues single link commands
// assumes software sequences mode set, row open and refresh itself
`timescale 1ns/100ps
module sdrci_ctl
(
	sdrci_if.ctl link,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef struct packed {
		logic cke;
		logic lat3;
		logic [sdrci_pkg::ROW_W-1:0] addr;
		logic [sdrci_pkg::BANK_W-1:0] bank;
		logic [sdrci_pkg::LANES-1:0] mask;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic rd_valid;
		logic busy;
		logic [2:0] wait_cnt;
		logic cs_n;
		logic [2:0] op;
		logic [sdrci_pkg::ROW_W-1:0] pin_addr;
		logic [sdrci_pkg::BANK_W-1:0] pin_bank;
		logic [sdrci_pkg::LANES-1:0] pin_mask;
		logic [31:0] dq_o;
		logic dq_oe;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} sdrci_ctl_s;

	sdrci_ctl_s state_r;
	sdrci_ctl_s state_nxt;
	logic first;
	logic done;

	assign first = psel && penable && !state_r.pready;
	assign done = psel && penable && state_r.pready;

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.cs_n = 1'b1;
		state_nxt.op = sdrci_pkg::OP_NOP;
		// idle lanes stay masked so trailing write beats change nothing
		state_nxt.pin_mask = '1;
		state_nxt.dq_oe = 1'b0;
		state_nxt.pready = first;
		if (first)
		begin
			state_nxt.pslverr = 1'b0;
			state_nxt.prdata = '0;
			case (paddr)
				sdrci_pkg::REG_CTRL:
				begin
					state_nxt.prdata[sdrci_pkg::CTRL_CKE_BIT] = state_r.cke;
					state_nxt.prdata[sdrci_pkg::CTRL_LAT3_BIT] = state_r.lat3;
				end
				sdrci_pkg::REG_ADDR:
					state_nxt.prdata = {12'h000, state_r.mask, 2'h0, state_r.bank, 1'b0,
						state_r.addr};
				sdrci_pkg::REG_WDATA: state_nxt.prdata = state_r.wdata;
				sdrci_pkg::REG_CMD: state_nxt.prdata = {29'h0000000, state_r.op};
				sdrci_pkg::REG_RDATA: state_nxt.prdata = state_r.rdata;
				sdrci_pkg::REG_STATUS:
				begin
					state_nxt.prdata[sdrci_pkg::STAT_BUSY_BIT] = state_r.busy;
					state_nxt.prdata[sdrci_pkg::STAT_RDV_BIT] = state_r.rd_valid;
				end
				default: state_nxt.pslverr = 1'b1;
			endcase
		end
		if (done && !pwrite && (paddr == sdrci_pkg::REG_RDATA))
			state_nxt.rd_valid = 1'b0;
		if (done && pwrite)
		begin
			case (paddr)
				sdrci_pkg::REG_CTRL:
				begin
					state_nxt.cke = pwdata[sdrci_pkg::CTRL_CKE_BIT];
					state_nxt.lat3 = pwdata[sdrci_pkg::CTRL_LAT3_BIT];
				end
				sdrci_pkg::REG_ADDR:
				begin
					state_nxt.addr = pwdata[sdrci_pkg::ROW_W-1:0];
					state_nxt.bank = pwdata[sdrci_pkg::ADDR_BANK_LSB +: sdrci_pkg::BANK_W];
					state_nxt.mask = pwdata[sdrci_pkg::ADDR_MASK_LSB +: sdrci_pkg::LANES];
				end
				sdrci_pkg::REG_WDATA: state_nxt.wdata = pwdata;
				sdrci_pkg::REG_CMD:
				begin
					// one command per write; dropped while a read is in flight
					if (!state_r.busy)
					begin
						state_nxt.cs_n = 1'b0;
						state_nxt.op = pwdata[2:0];
						state_nxt.pin_addr = state_r.addr;
						state_nxt.pin_bank = state_r.bank;
						if (pwdata[2:0] == sdrci_pkg::OP_WRITE)
						begin
							state_nxt.dq_o = state_r.wdata;
							state_nxt.dq_oe = 1'b1;
							state_nxt.pin_mask = state_r.mask;
						end
						if (pwdata[2:0] == sdrci_pkg::OP_READ)
						begin
							state_nxt.busy = 1'b1;
							state_nxt.wait_cnt = state_r.lat3 ? sdrci_pkg::LAT_WAIT_3 :
								sdrci_pkg::LAT_WAIT_2;
						end
					end
				end
				default:
				begin
				end
			endcase
		end
		if (state_r.wait_cnt != 3'h0)
		begin
			state_nxt.wait_cnt = state_r.wait_cnt - 3'h1;
			// only the first word of a read burst is kept
			if (state_r.wait_cnt == 3'h1)
			begin
				state_nxt.rdata = link.data_bus;
				state_nxt.rd_valid = 1'b1;
				state_nxt.busy = 1'b0;
			end
		end
	end

	always_ff @(posedge link.pclk or negedge link.presetn)
	begin
		if (!link.presetn)
		begin
			state_r <= '0;
			state_r.cke <= 1'b1;
			state_r.cs_n <= 1'b1;
			state_r.op <= sdrci_pkg::OP_NOP;
			state_r.pin_mask <= '1;
		end
		else
			state_r <= state_nxt;
	end

	assign link.clk_en = state_r.cke;
	assign link.chip_sel_n = state_r.cs_n;
	assign link.row_strobe_n = state_r.op[2];
	assign link.col_strobe_n = state_r.op[1];
	assign link.wr_en_n = state_r.op[0];
	assign link.bank_sel = state_r.pin_bank;
	assign link.addr_bus = state_r.pin_addr;
	assign link.byte_mask = state_r.pin_mask;
	assign link.ctl_dq_o = state_r.dq_o;
	assign link.ctl_dq_oe = state_r.dq_oe;
	assign prdata = state_r.prdata;
	assign pready = state_r.pready;
	assign pslverr = state_r.pslverr;
endmodule : sdrci_ctl

//--- verif/sdrci_properties.sv
// link checker: timing relations between controller end and sdram end
// assumes both ends share pclk and the bench wires the interface signals in
`timescale 1ns/100ps
module sdrci_properties
(
	input logic pclk,
	input logic presetn,
	input logic clk_en,
	input logic chip_sel_n,
	input logic row_strobe_n,
	input logic col_strobe_n,
	input logic wr_en_n,
	input logic [sdrci_pkg::BANK_W-1:0] bank_sel,
	input logic [sdrci_pkg::ROW_W-1:0] addr_bus,
	input logic ctl_dq_oe,
	input logic [sdrci_pkg::DATA_W-1:0] dev_dq_o,
	input logic dev_dq_oe
);
	typedef struct packed {logic cke; logic lat3; logic [3:0] open;} sdrci_chk_s;
	sdrci_chk_s st_r;
	sdrci_chk_s st_nxt;
	logic [2:0] op;
	logic take;
	logic rd;
	assign op = {row_strobe_n, col_strobe_n, wr_en_n};
	// a command counts only if clock enable was high at the previous edge
	assign take = st_r.cke && !chip_sel_n;
	assign rd = take && op == sdrci_pkg::OP_READ && st_r.open[bank_sel];
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.cke = clk_en;
		if (take && op == sdrci_pkg::OP_ROW_OPEN)
			st_nxt.open[bank_sel] = 1'b1;
		if (take && op == sdrci_pkg::OP_PRE)
			st_nxt.open = addr_bus[sdrci_pkg::AP_BIT] ? 4'h0 :
				st_r.open & ~(4'h1 << bank_sel);
		// auto precharge closes at once: the bench runs single-word bursts only
		if (take && (op == sdrci_pkg::OP_READ || op == sdrci_pkg::OP_WRITE)
			&& addr_bus[sdrci_pkg::AP_BIT])
			st_nxt.open[bank_sel] = 1'b0;
		if (take && op == sdrci_pkg::OP_MRS && st_r.open == 4'h0)
			st_nxt.lat3 = addr_bus[sdrci_pkg::MR_LAT_LSB +: sdrci_pkg::MR_LAT_W]
				== sdrci_pkg::LAT_3;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '{cke: 1'b1, lat3: 1'b0, open: 4'h0};
		else
			st_r <= st_nxt;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rd_lat2;
		rd && !st_r.lat3 |-> ##2 dev_dq_oe && !$past(dev_dq_oe);
	endproperty
	a_rd_lat2: assert property (p_rd_lat2) else $error("read data late at latency 2");
	property p_rd_lat3;
		rd && st_r.lat3 |-> ##3 dev_dq_oe && !$past(dev_dq_oe);
	endproperty
	a_rd_lat3: assert property (p_rd_lat3) else $error("read data late at latency 3");
	property p_rd_closed;
		take && op == sdrci_pkg::OP_READ && !st_r.open[bank_sel] |-> ##1 !dev_dq_oe [*3];
	endproperty
	a_rd_closed: assert property (p_rd_closed) else $error("closed bank returned data");
	property p_freeze;
		!st_r.cke |=> $stable(dev_dq_oe) && $stable(dev_dq_o);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved while clock off");
	property p_cs_pulse;
		!chip_sel_n |=> chip_sel_n;
	endproperty
	a_cs_pulse: assert property (p_cs_pulse) else $error("chip select held low");
	property p_wr_dq;
		ctl_dq_oe == (!chip_sel_n && op == sdrci_pkg::OP_WRITE);
	endproperty
	a_wr_dq: assert property (p_wr_dq) else $error("write data not with write");
	property p_no_clash;
		!(dev_dq_oe && ctl_dq_oe);
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
	property p_rose_cause;
		$rose(dev_dq_oe) |-> (st_r.lat3 ? $past(rd, 3) : $past(rd, 2));
	endproperty
	a_rose_cause: assert property (p_rose_cause) else $error("data with no read");
endmodule : sdrci_properties

//--- verif/sdr_sdram_command_interface_tb.sv
// bench: drives the controller over apb, watches the sdram end and the link
// assumes single-beat bursts and software-sequenced commands
`timescale 1ns/100ps
module sdr_sdram_command_interface_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] bank_open;
	logic power_down;
	logic self_refresh;
	logic [10:0] refresh_row;
	logic [31:0] rq;
	logic re;
	int bad_count = 0;
	int tests_run = 0;
	always #5 pclk = ~pclk;
	sdrci_if u_sdrci_if (.pclk(pclk), .presetn(presetn));
	sdrci_dev u_sdrci_dev (.link(u_sdrci_if), .bank_open(bank_open), .power_down(power_down),
		.self_refresh(self_refresh), .refresh_row(refresh_row));
	sdrci_ctl u_sdrci_ctl (.link(u_sdrci_if), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	sdrci_properties u_sdrci_properties (.pclk(pclk), .presetn(presetn),
		.clk_en(u_sdrci_if.clk_en), .chip_sel_n(u_sdrci_if.chip_sel_n),
		.row_strobe_n(u_sdrci_if.row_strobe_n), .col_strobe_n(u_sdrci_if.col_strobe_n),
		.wr_en_n(u_sdrci_if.wr_en_n), .bank_sel(u_sdrci_if.bank_sel),
		.addr_bus(u_sdrci_if.addr_bus), .ctl_dq_oe(u_sdrci_if.ctl_dq_oe),
		.dev_dq_o(u_sdrci_if.dev_dq_o), .dev_dq_oe(u_sdrci_if.dev_dq_oe));
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic hung(input string what);
		bad_count++;
		$display("mismatch at %0t: wait for %s ran out", $time, what);
		conclude();
	endtask : hung
	// entered right after a rising edge; leaves one idle edge so psel is never set twice at once
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			hung("pready");
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	function automatic logic [31:0] aw(input logic [1:0] b, input logic [10:0] a, input logic [3:0] m);
		return {12'h000, m, 2'h0, b, 1'b0, a};
	endfunction : aw
	task automatic cmd(input logic [2:0] op, input logic [31:0] w);
		int n;
		apb(1'b1, sdrci_pkg::REG_ADDR, w);
		apb(1'b1, sdrci_pkg::REG_CMD, {29'h0, op});
		for (n = 0; n < 20; n++)
		begin
			apb(1'b0, sdrci_pkg::REG_STATUS, 32'h0);
			if (rq[0] === 1'b0)
				break;
		end
		if (rq[0] !== 1'b0)
			hung("idle status");
	endtask : cmd
	task automatic rd_word(input logic [31:0] w, input logic [31:0] exp);
		cmd(sdrci_pkg::OP_READ, w);
		check({31'h0, rq[1]}, 32'h1, "read valid");
		apb(1'b0, sdrci_pkg::REG_RDATA, 32'h0);
		check(rq, exp, "read word");
	endtask : rd_word
	task automatic t_reset();
		check({28'h0, bank_open}, 32'h0, "banks after reset");
		check({21'h0, refresh_row}, 32'h0, "refresh count after reset");
		apb(1'b0, sdrci_pkg::REG_CTRL, 32'h0);
		check(rq, 32'h1, "control after reset");
		apb(1'b1, 8'h40, 32'h5);
		check({31'h0, re}, 32'h1, "unmapped error");
		$display("test reset done");
	endtask : t_reset
	task automatic t_write_read();
		cmd(sdrci_pkg::OP_MRS, aw(2'h0, 11'h020, 4'h0));
		cmd(sdrci_pkg::OP_ROW_OPEN, aw(2'h1, 11'h155, 4'h0));
		check({28'h0, bank_open}, 32'h2, "bank one open");
		apb(1'b1, sdrci_pkg::REG_WDATA, 32'ha1b2c3d4);
		cmd(sdrci_pkg::OP_WRITE, aw(2'h1, 11'h012, 4'h0));
		apb(1'b1, sdrci_pkg::REG_WDATA, 32'h11223344);
		// lanes 0 and 2 masked: those bytes keep the first write
		cmd(sdrci_pkg::OP_WRITE, aw(2'h1, 11'h012, 4'h5));
		rd_word(aw(2'h1, 11'h012, 4'h0), 32'h11b233d4);
		rd_word(aw(2'h1, 11'h112, 4'h0), 32'h11b233d4);
		$display("test write read done");
	endtask : t_write_read
	task automatic t_precharge();
		cmd(sdrci_pkg::OP_ROW_OPEN, aw(2'h3, 11'h7ff, 4'h0));
		check({28'h0, bank_open}, 32'ha, "banks one and three");
		cmd(sdrci_pkg::OP_PRE, aw(2'h1, 11'h000, 4'h0));
		check({28'h0, bank_open}, 32'h8, "single precharge");
		cmd(sdrci_pkg::OP_ROW_OPEN, aw(2'h0, 11'h001, 4'h0));
		cmd(sdrci_pkg::OP_PRE, aw(2'h2, 11'h400, 4'h0));
		check({28'h0, bank_open}, 32'h0, "all precharge");
		cmd(sdrci_pkg::OP_ROW_OPEN, aw(2'h2, 11'h0ab, 4'h0));
		check({28'h0, bank_open}, 32'h4, "bank two open");
		apb(1'b1, sdrci_pkg::REG_WDATA, 32'h5a5a5a5a);
		cmd(sdrci_pkg::OP_WRITE, aw(2'h2, 11'h412, 4'h0));
		check({28'h0, bank_open}, 32'h0, "auto precharge");
		// the bank is closed again, so this read must bring back no data
		cmd(sdrci_pkg::OP_READ, aw(2'h2, 11'h012, 4'h0));
		apb(1'b0, sdrci_pkg::REG_RDATA, 32'h0);
		check(rq, 32'h0, "closed bank read");
		$display("test precharge done");
	endtask : t_precharge
	task automatic t_power();
		int n;
		cmd(sdrci_pkg::OP_REF, 32'h0);
		cmd(sdrci_pkg::OP_REF, 32'h0);
		check({21'h0, refresh_row}, 32'h2, "refresh count");
		apb(1'b1, sdrci_pkg::REG_CTRL, 32'h0);
		for (n = 0; n < 20 && power_down !== 1'b1; n++)
			@(posedge pclk);
		if (power_down !== 1'b1)
			hung("power down entry");
		check({31'h0, power_down}, 32'h1, "power down entry");
		check({31'h0, self_refresh}, 32'h0, "plain power down");
		apb(1'b1, sdrci_pkg::REG_CTRL, 32'h1);
		for (n = 0; n < 20 && power_down !== 1'b0; n++)
			@(posedge pclk);
		if (power_down !== 1'b0)
			hung("power down exit");
		check({31'h0, power_down}, 32'h0, "power down exit");
		$display("test power done");
	endtask : t_power
	task automatic t_lat3();
		cmd(sdrci_pkg::OP_MRS, aw(2'h0, 11'h030, 4'h0));
		apb(1'b1, sdrci_pkg::REG_CTRL, 32'h3);
		cmd(sdrci_pkg::OP_ROW_OPEN, aw(2'h1, 11'h155, 4'h0));
		rd_word(aw(2'h1, 11'h012, 4'h0), 32'h11b233d4);
		$display("test latency three done");
	endtask : t_lat3
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_write_read();
		t_precharge();
		t_power();
		t_lat3();
		conclude();
	end
endmodule : sdr_sdram_command_interface_tb
